// *** rtl/dim_pkg.sv ***
`default_nettype none
// Shared constants for the digital input function mapper.
package dim_pkg;
	// Number of input pins and width of a function selector.
	localparam int NUM_INPUTS = 7;
	localparam int SEL_W      = 16;
	localparam int NUM_FUNCS  = 22;
	localparam int MODE_W     = 8;

	// Function indices into the decode table.
	localparam int FN_ENABLE   = 0;
	localparam int FN_FAULT    = 1;
	localparam int FN_MODE     = 2;
	localparam int FN_PCTL     = 3;
	localparam int FN_PLIM     = 4;
	localparam int FN_NLIM     = 5;
	localparam int FN_HOME     = 6;
	localparam int FN_REV      = 7;
	localparam int FN_SPD0     = 8;
	localparam int FN_SPD1     = 9;
	localparam int FN_SPD2     = 10;
	localparam int FN_POS0     = 11;
	localparam int FN_POS1     = 12;
	localparam int FN_POS2     = 13;
	localparam int FN_MUL0     = 14;
	localparam int FN_MUL1     = 15;
	localparam int FN_MUL2     = 16;
	localparam int FN_GAIN0    = 17;
	localparam int FN_GAIN1    = 18;
	localparam int FN_QSTOP    = 19;
	localparam int FN_HOMSTART = 20;
	localparam int FN_ACTIVATE = 21;

	// Bit-coded selector values; bit 15 marks the extended function group.
	localparam logic [SEL_W-1:0] FN_CODE [0:NUM_FUNCS-1] = '{
		16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
		16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h8001, 16'h0400,
		16'h0800, 16'h8002, 16'h8004, 16'h8008, 16'h8010, 16'h8020,
		16'h8040, 16'h1000, 16'h2000, 16'h4000};
	localparam int SEL_GROUP_BIT = 15;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFS_STORE   = 8'h00;
	localparam logic [7:0] OFS_SEL0    = 8'h04;
	localparam logic [7:0] OFS_POL     = 8'h20;
	localparam logic [7:0] OFS_LIMPOL  = 8'h24;
	localparam logic [7:0] OFS_MODE0   = 8'h28;
	localparam logic [7:0] OFS_MODE1   = 8'h2C;
	localparam logic [7:0] OFS_AUTO    = 8'h30;
	localparam logic [7:0] OFS_INSTAT  = 8'h34;
	localparam logic [7:0] OFS_FNSTAT  = 8'h38;
	localparam logic [7:0] OFS_CTRL    = 8'h3C;

	// Reset values.
	localparam logic [SEL_W-1:0] RST_SEL [0:NUM_INPUTS-1] = '{
		16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040};
	localparam logic [NUM_INPUTS-1:0] RST_POL    = 7'h7F;
	localparam logic [1:0]            RST_LIMPOL = 2'h0;
	localparam logic [MODE_W-1:0]     RST_MODE0  = 8'h00;
	localparam logic [MODE_W-1:0]     RST_MODE1  = 8'h00;
	localparam logic                  RST_AUTO   = 1'b0;

	// Signed speed mode codes that allow speed reversal.
	localparam logic [MODE_W-1:0] MODE_SPEED_POS = 8'h03;
	localparam logic [MODE_W-1:0] MODE_SPEED_NEG = 8'hFD;
endpackage
`default_nettype wire

// *** rtl/dim_top.sv ***
// Local design decisions: the placing of the registers and the APB register port.
`default_nettype none
//Contract
// - Disabled code drives no function.
// - Valid enable input keeps drive enabled.
// - Fault reset acts on rising edge.
// - Mode input selects one of two modes.
// - Proportional input stops velocity integration.
// - Positive limit blocks forward, polarity configurable.
// - Negative limit blocks reverse, polarity configurable.
// - Homing input is origin reference.
// - Reverse input negates speed in speed mode.
// - Speed selector bits form speed index.
// - Position selector bits form position index.
// - Multi selector bits form gear index.
// - Gain switch bits choose gain set.
// - Quick stop releases the motor shaft.
// - After quick stop, stay disabled until re-enabled.
// - Homing start on each rising edge.
// - Activate command on each rising edge.
// - Any input can carry enable code.
// - No enable input plus auto setting enables.
// - Selectors are bit-coded function values.
// - Inputs default to normally open.
module dim_top
	import dim_pkg::*;
(
	// Clock and reset.
	input  wire logic                        CLK_SYS_I,
	input  wire logic                        RST_I,
	// APB slave port.
	input  wire logic                        PSEL_I,
	input  wire logic                        PENABLE_I,
	input  wire logic                        PWRITE_I,
	input  wire logic [7:0]                  PADDR_I,
	input  wire logic [31:0]                 PWDATA_I,
	output logic [31:0]                      PRDATA_O,
	output logic                             PREADY_O,
	output logic                             PSLVERR_O,
	// Raw digital input pins.
	input  wire logic [dim_pkg::NUM_INPUTS-1:0] DIN_I,
	// Drive control levels.
	output logic                             DRIVE_ENABLE_O,
	output logic                             SHAFT_RELEASE_O,
	output logic [dim_pkg::MODE_W-1:0]       OP_MODE_O,
	output logic                             VEL_P_ONLY_O,
	output logic                             FWD_BLOCK_O,
	output logic                             REV_BLOCK_O,
	output logic                             HOME_SWITCH_O,
	output logic                             SPEED_NEGATE_O,
	// Selector indices.
	output logic [2:0]                       SPEED_INDEX_O,
	output logic [2:0]                       POS_INDEX_O,
	output logic [2:0]                       GEAR_INDEX_O,
	output logic [1:0]                       GAIN_INDEX_O,
	// One-cycle event pulses.
	output logic                             FAULT_CLEAR_O,
	output logic                             HOMING_START_O,
	output logic                             ACTIVATE_O,
	output logic                             STORE_REQ_O
);
	import dim_pkg::*;

	// Data flow: pins are synchronised, corrected for polarity, decoded against
	// each input's selector into one level per function, and then registered.
	// Every level output therefore trails its pin by three clock edges, and every
	// event pulse follows the rising edge of its function by the same amount.
	// Several inputs may carry one function; their valid levels are ORed.

	// Two-flop synchroniser stages for the pins.
	logic [NUM_INPUTS-1:0] din_meta_r;   // First stage, read only by the second.
	logic [NUM_INPUTS-1:0] din_sync_r;   // Second stage, safe to use.

	// Configuration registers.
	// All of them reset to the values that a fresh device carries.
	logic [SEL_W-1:0]      sel_r [0:NUM_INPUTS-1]; // Function selector per input.
	logic [NUM_INPUTS-1:0] pol_r;        // 1 means normally open.
	logic [1:0]            limpol_r;     // 0 means limit switch normally closed.
	logic [MODE_W-1:0]     mode0_r;      // Mode while the mode input is invalid.
	logic [MODE_W-1:0]     mode1_r;      // Mode while the mode input is valid.
	logic                  auto_r;       // Automatic switch-on setting.

	// Decoded function state.
	logic [NUM_FUNCS-1:0]  fn_valid;     // Function asserted by any input.
	logic [NUM_FUNCS-1:0]  fn_prev_r;    // Previous cycle, for edge detection.
	logic [NUM_FUNCS-1:0]  fn_rise;      // Rising edge of each function.
	logic [NUM_INPUTS-1:0] in_valid;     // Polarity corrected levels.
	logic [NUM_INPUTS-1:0] en_mapped;    // Inputs carrying the enable code.

	// Enable and quick stop lock.
	// The lock remembers a quick stop after its input has gone away.
	logic                  en_src;       // Enable request from input or auto.
	logic                  en_src_prev_r;
	logic                  qs_lock_r;    // Held after a quick stop.
	logic                  qs_lock_nxt;
	logic                  sw_reenable;  // Software re-enable strobe.

	// Bus decode wires and the selected mode.
	// The selector matches are shared by the read multiplexer and the write decode so that
	// both always agree on which word an address selects.
	logic                  apb_setup;
	logic                  apb_wr;
	logic                  addr_hit;
	logic [31:0]           rd_mux;
	logic [NUM_INPUTS-1:0] sel_hit;
	logic [MODE_W-1:0]     mode_sel;

	// Synchronise pins first so every edge is seen once and cleanly.
	// The first stage may go metastable when a pin moves near the clock edge,
	// so nothing but the second stage ever reads it.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			din_meta_r <= '0;
			din_sync_r <= '0;
		end else begin
			din_meta_r <= DIN_I;
			din_sync_r <= din_meta_r;
		end
	end

	// Polarity correction: a set bit makes a high pin the valid level.
	// With the reset polarity a pin that sits low reads as invalid, which is the
	// normally open default; a cleared bit turns the pin into a normally closed one.
	assign in_valid = ~(din_sync_r ^ pol_r);

	// Per function, OR together the inputs whose selector carries its code.
	// The group bit must match too, otherwise 16'h8001 would alias enable.
	// Codes with bit 15 clear form the base group and codes with it set the
	// extended group; the low bits only mean something within their group.
	// A selector that holds several bits in one group drives all of them.
	genvar f, i;
	generate
		for (f = 0; f < NUM_FUNCS; f++) begin : g_fn
			logic [NUM_INPUTS-1:0] hit;
			logic                  inv;
			// Limits default to normally closed, so an open contact is a limit.
			// A set limit polarity bit turns the switch into a normally open one.
			if (f == FN_PLIM) begin : g_pl
				assign inv = ~limpol_r[0];
			end else if (f == FN_NLIM) begin : g_nl
				assign inv = ~limpol_r[1];
			end else begin : g_no
				assign inv = 1'b0;
			end
			for (i = 0; i < NUM_INPUTS; i++) begin : g_in
				// A zero selector matches no code and so drives nothing.
				assign hit[i] = (sel_r[i][SEL_GROUP_BIT] == FN_CODE[f][SEL_GROUP_BIT])
					&& (|(sel_r[i][SEL_W-2:0] & FN_CODE[f][SEL_W-2:0]))
					&& (in_valid[i] ^ inv);
			end
			assign fn_valid[f] = |hit;
		end
		// Mark inputs whose selector holds the enable bit.
		for (i = 0; i < NUM_INPUTS; i++) begin : g_en
			assign en_mapped[i] = ~sel_r[i][SEL_GROUP_BIT]
				& sel_r[i][FN_ENABLE];
		end
	endgenerate

	// Edge history of all functions.
	// Reset clears the history, so a function that is valid at the first cycle
	// after reset yields one edge then, just like a pin that rises at power-on.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			fn_prev_r <= '0;
		end else begin
			fn_prev_r <= fn_valid;
		end
	end

	assign fn_rise = fn_valid & ~fn_prev_r;

	// Enable comes from a mapped input, or from the auto setting when none is mapped.
	// The choice is made on the selectors, not on the pin levels: as soon as any
	// selector carries enable, the automatic setting no longer has any effect.
	assign en_src = (|en_mapped) ? fn_valid[FN_ENABLE] : auto_r;

	// Quick stop sets the lock; a fresh enable edge or software clears it.
	// Set wins, so a re-enable during an active quick stop has no effect.
	// Limitation: with the automatic setting the enable source never rises again,
	// so after a quick stop only the software re-enable brings the drive back.
	assign sw_reenable = apb_wr && (PADDR_I == OFS_CTRL) && PWDATA_I[0];
	always_comb begin
		qs_lock_nxt = qs_lock_r;
		if (fn_valid[FN_QSTOP]) begin
			qs_lock_nxt = 1'b1;
		end else if ((en_src & ~en_src_prev_r) | sw_reenable) begin
			qs_lock_nxt = 1'b0;
		end
	end

	// Lock and enable edge history.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			qs_lock_r     <= 1'b0;
			en_src_prev_r <= 1'b0;
		end else begin
			qs_lock_r     <= qs_lock_nxt;
			en_src_prev_r <= en_src;
		end
	end

	// Mode selection follows the mode input level.
	// Both modes are plain codes; this block does not check that they are legal.
	assign mode_sel = fn_valid[FN_MODE] ? mode1_r : mode0_r;

	// Registered control outputs; one cycle after the decoded level.
	// Registering every level gives glitch-free outputs at the cost of one cycle.
	// The enable term uses the next lock value so that quick stop drops the drive
	// at the same edge that raises the shaft release, never one edge later.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			DRIVE_ENABLE_O  <= 1'b0;
			SHAFT_RELEASE_O <= 1'b0;
			OP_MODE_O       <= RST_MODE0;
			VEL_P_ONLY_O    <= 1'b0;
			FWD_BLOCK_O     <= 1'b0;
			REV_BLOCK_O     <= 1'b0;
			HOME_SWITCH_O   <= 1'b0;
			SPEED_NEGATE_O  <= 1'b0;
		end else begin
			DRIVE_ENABLE_O  <= en_src & ~qs_lock_nxt;
			SHAFT_RELEASE_O <= fn_valid[FN_QSTOP];
			OP_MODE_O       <= mode_sel;
			VEL_P_ONLY_O    <= fn_valid[FN_PCTL];
			FWD_BLOCK_O     <= fn_valid[FN_PLIM];
			REV_BLOCK_O     <= fn_valid[FN_NLIM];
			HOME_SWITCH_O   <= fn_valid[FN_HOME];
			SPEED_NEGATE_O  <= fn_valid[FN_REV] && ((mode_sel == MODE_SPEED_POS)
				|| (mode_sel == MODE_SPEED_NEG));
		end
	end

	// Index outputs gathered from the selector bits, bit 0 first.
	// An unmapped selector bit reads as zero, so an index only counts the bits
	// that some input actually carries.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			SPEED_INDEX_O <= '0;
			POS_INDEX_O   <= '0;
			GEAR_INDEX_O  <= '0;
			GAIN_INDEX_O  <= '0;
		end else begin
			SPEED_INDEX_O <= {fn_valid[FN_SPD2], fn_valid[FN_SPD1], fn_valid[FN_SPD0]};
			POS_INDEX_O   <= {fn_valid[FN_POS2], fn_valid[FN_POS1], fn_valid[FN_POS0]};
			GEAR_INDEX_O  <= {fn_valid[FN_MUL2], fn_valid[FN_MUL1], fn_valid[FN_MUL0]};
			GAIN_INDEX_O  <= {fn_valid[FN_GAIN1], fn_valid[FN_GAIN0]};
		end
	end

	// Event pulses, one cycle per detected rising edge.
	// A function must go invalid for at least one synchronised cycle before it
	// can give a second pulse.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			FAULT_CLEAR_O  <= 1'b0;
			HOMING_START_O <= 1'b0;
			ACTIVATE_O     <= 1'b0;
		end else begin
			FAULT_CLEAR_O  <= fn_rise[FN_FAULT];
			HOMING_START_O <= fn_rise[FN_HOMSTART];
			ACTIVATE_O     <= fn_rise[FN_ACTIVATE];
		end
	end

	// APB: zero wait states; read data is latched in the setup cycle.
	// Because the answer never waits, ready is a constant; read data and the error
	// flag are captured at the setup edge and stand until the next setup cycle.
	assign apb_setup = PSEL_I & ~PENABLE_I;
	assign apb_wr    = PSEL_I & PENABLE_I & PWRITE_I;
	assign PREADY_O  = 1'b1;

	// Selector window match per input.
	// Selector words follow one another at a stride of one word from the first.
	generate
		for (i = 0; i < NUM_INPUTS; i++) begin : g_dec
			assign sel_hit[i] = (PADDR_I == 8'(OFS_SEL0 + 8'(4 * i)));
		end
	endgenerate

	// Address map check, shared by read and write.
	// Any other address answers with an error, reads zero and ignores a write.
	assign addr_hit = (|sel_hit) || (PADDR_I == OFS_STORE) || (PADDR_I == OFS_POL)
		|| (PADDR_I == OFS_LIMPOL) || (PADDR_I == OFS_MODE0) || (PADDR_I == OFS_MODE1)
		|| (PADDR_I == OFS_AUTO) || (PADDR_I == OFS_INSTAT) || (PADDR_I == OFS_FNSTAT)
		|| (PADDR_I == OFS_CTRL);

	// Read multiplexer; unused bits read as zero.
	// The status words show the synchronised pins and the decoded levels, which
	// lets software see what the decode sees without probing the pins.
	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int k = 0; k < NUM_INPUTS; k++) begin
			if (sel_hit[k]) begin
				rd_mux = {16'h0000, sel_r[k]};
			end
		end
		if (PADDR_I == OFS_POL) begin
			rd_mux = {25'h0000000, pol_r};
		end else if (PADDR_I == OFS_LIMPOL) begin
			rd_mux = {30'h00000000, limpol_r};
		end else if (PADDR_I == OFS_MODE0) begin
			rd_mux = {24'h000000, mode0_r};
		end else if (PADDR_I == OFS_MODE1) begin
			rd_mux = {24'h000000, mode1_r};
		end else if (PADDR_I == OFS_AUTO) begin
			rd_mux = {31'h00000000, auto_r};
		end else if (PADDR_I == OFS_INSTAT) begin
			rd_mux = {25'h0000000, din_sync_r};
		end else if (PADDR_I == OFS_FNSTAT) begin
			rd_mux = {10'h000, fn_valid};
		end else if (PADDR_I == OFS_CTRL) begin
			rd_mux = {30'h00000000, qs_lock_r, DRIVE_ENABLE_O};
		end
	end

	// Bus answer registers.
	// A write returns zero read data so that nothing stale leaks onto the bus.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			PRDATA_O  <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else if (apb_setup) begin
			PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_mux;
			PSLVERR_O <= ~addr_hit;
		end
	end

	// Configuration writes take effect in the access cycle.
	// The read-only status words and the store word fall through unchanged.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			for (int k = 0; k < NUM_INPUTS; k++) begin
				sel_r[k] <= RST_SEL[k];
			end
			pol_r    <= RST_POL;
			limpol_r <= RST_LIMPOL;
			mode0_r  <= RST_MODE0;
			mode1_r  <= RST_MODE1;
			auto_r   <= RST_AUTO;
		end else if (apb_wr) begin
			for (int k = 0; k < NUM_INPUTS; k++) begin
				if (sel_hit[k]) begin
					sel_r[k] <= PWDATA_I[SEL_W-1:0];
				end
			end
			if (PADDR_I == OFS_POL) begin
				pol_r <= PWDATA_I[NUM_INPUTS-1:0];
			end else if (PADDR_I == OFS_LIMPOL) begin
				limpol_r <= PWDATA_I[1:0];
			end else if (PADDR_I == OFS_MODE0) begin
				mode0_r <= PWDATA_I[MODE_W-1:0];
			end else if (PADDR_I == OFS_MODE1) begin
				mode1_r <= PWDATA_I[MODE_W-1:0];
			end else if (PADDR_I == OFS_AUTO) begin
				auto_r <= PWDATA_I[0];
			end
		end
	end

	// The store strobe asks the nonvolatile side to copy the current settings.
	// The copy itself lives outside; this block only raises the request.
	// A write of zero to the store word is accepted and does nothing.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			STORE_REQ_O <= 1'b0;
		end else begin
			STORE_REQ_O <= apb_wr && (PADDR_I == OFS_STORE) && PWDATA_I[0];
		end
	end
endmodule
`default_nettype wire

// *** verification/dim_top_sva.sv ***
`default_nettype none
// Timing relations of the mapper ports that hold in every configuration.
module dim_chk
	import dim_pkg::*;
(
	// Clock, reset and bus.
	input wire logic        CLK_SYS_I,
	input wire logic        RST_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [7:0]  PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PSLVERR_O,
	// Drive levels and pulses.
	input wire logic        DRIVE_ENABLE_O,
	input wire logic        SHAFT_RELEASE_O,
	input wire logic        FAULT_CLEAR_O,
	input wire logic        HOMING_START_O,
	input wire logic        ACTIVATE_O,
	input wire logic        STORE_REQ_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	// Access phase of a write of bit 0 to the store word.
	sequence s_store_wr;
		PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFS_STORE && PWDATA_I[0];
	endsequence
	// Access phase beyond the last mapped word.
	sequence s_unmapped;
		PSEL_I && PENABLE_I && PADDR_I > OFS_CTRL;
	endsequence
	a_store_pulse: assert property (s_store_wr |=> STORE_REQ_O ##1 !STORE_REQ_O)
		else $error("store request is not a single pulse");
	a_store_cause: assert property (STORE_REQ_O |->
		$past(PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFS_STORE))
		else $error("store request without a store write");
	a_unmapped_err: assert property (s_unmapped |-> PSLVERR_O && PRDATA_O == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (PSEL_I && PENABLE_I && PADDR_I <= OFS_CTRL
		&& PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O)
		else $error("mapped access refused");
	a_fault_single: assert property (FAULT_CLEAR_O |=> !FAULT_CLEAR_O)
		else $error("fault clear longer than one cycle");
	a_homing_single: assert property (HOMING_START_O |=> !HOMING_START_O)
		else $error("homing start longer than one cycle");
	a_activate_single: assert property (ACTIVATE_O |=> !ACTIVATE_O)
		else $error("activate longer than one cycle");
	a_release_off: assert property (SHAFT_RELEASE_O |-> !DRIVE_ENABLE_O)
		else $error("drive enabled while shaft released");
	a_qstop_lock: assert property ($fell(SHAFT_RELEASE_O) |-> !DRIVE_ENABLE_O [*2])
		else $error("drive enabled right after quick stop");
endmodule
bind dim_top dim_chk u_chk (.CLK_SYS_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
	.PWDATA_I, .PRDATA_O, .PSLVERR_O, .DRIVE_ENABLE_O, .SHAFT_RELEASE_O, .FAULT_CLEAR_O,
	.HOMING_START_O, .ACTIVATE_O, .STORE_REQ_O);
`default_nettype wire

// *** verification/dim_switches.sv ***
`default_nettype none
// Bank of external contacts; each moves one clock after its command, like a relay output.
module dim_switches (
	input  wire logic       clk_i,
	input  wire logic [6:0] cmd_i,
	output logic      [6:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Contacts only move just after a rising edge, so no pin changes mid-cycle.
	always_ff @(posedge clk_i) begin
		pin_o <= cmd_i;
	end
endmodule
`default_nettype wire

// *** verification/dim_top_tb.sv ***
`default_nettype none
// Self-checking bench for the input function mapper.
module dim_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dim_pkg::*;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        psel = 1'h0;
	logic        pen = 1'h0;
	logic        pwr = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [6:0]  cmd = 7'h00;
	logic [31:0] rd, prdata;
	logic [7:0]  opm;
	logic [6:0]  din;
	logic [2:0]  spd, pos, gear;
	logic [1:0]  gain;
	logic        er, pready, pslverr, den, srel, vpo, fwd, rev, hsw, neg, fclr, hst, act, stq;
	int          fails = 0;
	int          check_count = 0;
	wire logic [2:0]  pl = {act, hst, fclr};
	wire logic [11:0] ix = {1'h0, gain, gear, pos, spd};
	dim_top u_dut (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .DIN_I(din), .DRIVE_ENABLE_O(den),
		.SHAFT_RELEASE_O(srel), .OP_MODE_O(opm), .VEL_P_ONLY_O(vpo), .FWD_BLOCK_O(fwd),
		.REV_BLOCK_O(rev), .HOME_SWITCH_O(hsw), .SPEED_NEGATE_O(neg), .SPEED_INDEX_O(spd),
		.POS_INDEX_O(pos), .GEAR_INDEX_O(gear), .GAIN_INDEX_O(gain), .FAULT_CLEAR_O(fclr),
		.HOMING_START_O(hst), .ACTIVATE_O(act), .STORE_REQ_O(stq));
	dim_switches u_sw (.clk_i(clk), .cmd_i(cmd), .pin_o(din));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// One bus transfer; it waits on ready because the slave could stretch the access.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (pready !== 1'h1) begin
			fails++;
			close_out();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'h0;
			pen <= 1'h0;
		end
	endtask
	function automatic logic [7:0] sa(input int n);
		return OFS_SEL0 + 8'(4 * (n - 1));
	endfunction
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(n, e, rd);
	endtask
	// Contacts move, then three sync and decode edges plus the contact delay pass.
	task automatic pins(input logic [6:0] v);
		@(posedge clk);
		cmd <= v;
		repeat (6) @(posedge clk);
	endtask
	task automatic t_reset;
		for (int n = 1; n <= 7; n++) begin
			rc("selector", sa(n), 32'h1 << (n - 1));
		end
		rc("polarity", OFS_POL, 32'h7F);
		rc("unmapped", 8'h40, 32'h0);
		chk("slverr", 1, er);
		chk("fwd block", 1, fwd);
		chk("rev block", 1, rev);
	endtask
	task automatic t_levels;
		apb(1'h1, OFS_MODE0, 32'hFC);
		apb(1'h1, OFS_MODE1, 32'h03);
		pins(7'h7F);
		chk("enable", 1, den);
		chk("mode", 8'h03, opm);
		chk("p only", 1, vpo);
		chk("fwd block", 0, fwd);
		chk("rev block", 0, rev);
		chk("home", 1, hsw);
		apb(1'h1, OFS_LIMPOL, 32'h3);
		pins(7'h7B);
		chk("mode", 8'hFC, opm);
		chk("fwd block", 1, fwd);
		chk("rev block", 1, rev);
		apb(1'h1, OFS_LIMPOL, 32'h0);
		apb(1'h1, sa(7), {16'h0, FN_CODE[FN_REV]});
		pins(7'h7F);
		chk("negate", 1, neg);
		pins(7'h7B);
		chk("negate", 0, neg);
		apb(1'h1, OFS_MODE1, 32'hFD);
		pins(7'h7F);
		chk("negate", 1, neg);
	endtask
	// Status words, software re-enable after a quick stop, and a refused write.
	task automatic t_ctrl;
		rc("pins", OFS_INSTAT, 32'h77);
		rc("functions", OFS_FNSTAT,
			(1 << FN_ENABLE) | (1 << FN_FAULT) | (1 << FN_MODE) | (1 << FN_REV));
		pins(7'h7F);
		pins(7'h77);
		rc("ctrl", OFS_CTRL, 32'h2);
		apb(1'h1, OFS_CTRL, 32'h1);
		rc("ctrl", OFS_CTRL, 32'h1);
		apb(1'h1, 8'h40, 32'h1);
		chk("slverr", 1, er);
	endtask
	task automatic t_qstop;
		apb(1'h1, sa(4), {16'h0, FN_CODE[FN_QSTOP]});
		pins(7'h7F);
		chk("release", 1, srel);
		chk("enable", 0, den);
		pins(7'h77);
		chk("release", 0, srel);
		chk("enable", 0, den);
		pins(7'h76);
		pins(7'h77);
		chk("enable", 1, den);
	endtask
	task automatic t_enable;
		pins(7'h00);
		apb(1'h1, sa(1), 32'h0);
		apb(1'h1, sa(2), {16'h0, FN_CODE[FN_ENABLE]});
		pins(7'h01);
		chk("enable", 0, den);
		pins(7'h02);
		chk("enable", 1, den);
		apb(1'h1, sa(2), 32'h0);
		apb(1'h1, OFS_AUTO, 32'h1);
		pins(7'h00);
		chk("enable", 1, den);
		apb(1'h1, OFS_AUTO, 32'h0);
		apb(1'h1, OFS_STORE, 32'h1);
		rc("store", OFS_STORE, 32'h0);
	endtask
	// Each pin rise must give exactly one pulse, however long the pin stays high.
	task automatic t_pulse(input int k, input int f);
		int cnt;
		cnt = 0;
		apb(1'h1, sa(3), {16'h0, FN_CODE[f]});
		@(posedge clk);
		cmd <= 7'h04;
		repeat (10) begin
			@(posedge clk);
			if (pl[k] === 1'h1) begin
				cnt++;
			end
		end
		chk("pulse count", 1, cnt);
		pins(7'h00);
	endtask
	task automatic t_index;
		int bs [4] = '{FN_SPD0, FN_POS0, FN_MUL0, FN_GAIN0};
		for (int g = 0; g < 4; g++) begin
			for (int b = 0; b < 3; b++) begin
				apb(1'h1, sa(5 + b), (g == 3 && b == 2) ? 32'h0 : {16'h0, FN_CODE[bs[g] + b]});
			end
			pins(7'h50);
			chk("index", (g == 3) ? 3'h1 : 3'h5, ix[3*g +: 3]);
			pins(7'h00);
		end
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_levels();
		t_qstop();
		t_ctrl();
		t_enable();
		t_pulse(0, FN_FAULT);
		t_pulse(1, FN_HOMSTART);
		t_pulse(2, FN_ACTIVATE);
		t_index();
		close_out();
	end
	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		close_out();
	end
endmodule
`default_nettype wire
